/* File: verilog/clock_ctrl_cfg.svh */
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef CLOCK_CTRL_CFG_SVH
`define CLOCK_CTRL_CFG_SVH

// ****************************************
// Register word indices (byte address = 4 x index)
// ****************************************
`define IDX_FAST_PRESCALE 16'h701A
`define IDX_SLOW_PRESCALE 16'h701B
`define IDX_CLK_GATING 16'h701C
`define IDX_LOW_POWER_A 16'h701E
`define IDX_LOW_POWER_B 16'h701F
`define IDX_RATIO 16'h7021
`define IDX_STATUS 16'h7022
`define IDX_WD_COUNT 16'h7023
`define IDX_WD_KEY 16'h7025
`define IDX_WD_CONTROL 16'h7029

// ****************************************
// Fields and reset values
// ****************************************
`define REG_RESET 16'h0000
`define RATIO_RESET 4'h0
`define RATIO_MSB 3
`define RATIO_LSB 0
`define RATIO_BYPASS_MAX 4'h1
`define WD_KEY_FIRST 16'h0055
`define WD_KEY_SECOND 16'h00AA
`define WD_DISABLE_BIT 6
`define WD_COUNT_MAX 8'hFF
`define STAT_LOCKED_BIT 0
`define STAT_LOST_BIT 1
`define STAT_PLLOFF_BIT 2
`define STAT_LIMP_BIT 3

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 4
`define LOSS_TIME_NS 1000
`define LOSS_CYCLES ((`LOSS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LIMP_PERIOD_NS 500
`define LIMP_CYCLES (`LIMP_PERIOD_NS / `CLK_PERIOD_NS)
`define LOCK_INPUT_CYCLES 131072

`endif

/* File: verilog/clock_ctrl_pkg.sv */
// Types shared by the clock control block
package clock_ctrl_pkg;

    // Clock source selection state
    typedef enum logic [2:0] {
        ST_BYPASS = 3'b000,
        ST_PLLOFF = 3'b001,
        ST_LOCKING = 3'b010,
        ST_RUN = 3'b011,
        ST_LIMP = 3'b100
    } clk_state_t;

    typedef logic [15:0] word_t; // One 16-bit register word

endpackage : clock_ctrl_pkg

/* File: verilog/rate_multiplier.sv */
// Fractional tick generator giving n/2 ticks per input clock period
`timescale 1ns/1ns
`include "clock_ctrl_cfg.svh"
module rate_multiplier (
    input wire logic mclk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic in_edge, // One-cycle pulse per input clock rising edge
    input wire logic [3:0] mult, // Multiplication factor n
    output logic tick // One-cycle pulse per system clock period
);
    logic [15:0] count_q; // Cycles since the last input edge
    logic [15:0] period_q; // Last measured input period
    logic [20:0] acc_q; // Phase accumulator
    logic [20:0] limit; // Two input periods, the wrap point
    logic [20:0] acc_sum; // Accumulator plus step

    assign limit = {4'h0, period_q, 1'b0};
    assign acc_sum = acc_q + {17'h00000, mult};

    // ****************************************
    // Period measurement
    // ****************************************
    // Count saturates, but a very slow input then wraps the measure to zero, which stops the ticks
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            count_q <= 16'h0000;
            period_q <= 16'h0000;
        end else if (ce) begin
            if (in_edge) begin
                period_q <= count_q + 16'h0001;
                count_q <= 16'h0000;
            end else if (count_q != 16'hFFFF) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // ****************************************
    // Accumulator
    // ****************************************
    // Adding n per cycle and wrapping at 2 x period gives n/2 ticks per period;
    // one tick per mclk at most, so n/2 x input must stay below mclk
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            acc_q <= 21'h000000;
            tick <= 1'b0;
        end else if (ce) begin
            if (period_q != 16'h0000 && acc_sum >= limit) begin
                acc_q <= acc_sum - limit;
                tick <= 1'b1;
            end else begin
                acc_q <= (period_q == 16'h0000) ? 21'h000000 : acc_sum;
                tick <= 1'b0;
            end
        end
    end
endmodule : rate_multiplier

/* File: verilog/clock_control.sv */
// Clock ratio, limp clock and protected system-control register block
`timescale 1ns/1ns
`include "clock_ctrl_cfg.svh"
module clock_control #(
    parameter int LOCK_CYCLES = `LOCK_INPUT_CYCLES // Input edges to PLL lock
) (
    input wire logic mclk, // System clock, 250 MHz
    input wire logic reset_n, // External reset pin, synchronous, active low
    input wire logic debug_reset_n, // Debugger reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic input_clock, // Crystal or oscillator clock pin
    input wire logic pll_disable_pin_n, // Strap: low at reset disables the PLL
    input wire logic protected_access_unlock, // Protected register access open
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [17:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic system_clock_tick, // One pulse per system clock period
    output logic watchdog_wake_irq, // Pulse when the watchdog count wraps
    output logic input_lost, // Input clock lost
    output logic limp_active // Limp clock in use
);
    import clock_ctrl_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic in_s1_q, in_s2_q, in_s3_q; // Input clock synchroniser and edge stage
    logic dis_s1_q, dis_s2_q; // Strap synchroniser
    logic in_edge; // Input clock rising edge
    logic [8:0] loss_cnt_q; // Cycles without an input edge
    logic strap_off_q; // PLL disabled by strap
    clk_state_t state_q; // Clock source state
    logic [17:0] lock_cnt_q; // Input edges since ratio write
    logic [3:0] ratio_q; // Multiplication code
    word_t fast_pre_q, slow_pre_q, gating_q, lpa_q, lpb_q; // Storage-only registers
    word_t wd_key_q, wd_ctrl_q; // Watchdog key and control
    logic [7:0] wd_cnt_q; // Watchdog counter
    logic key_armed_q; // First key value seen
    logic half_q; // Divide-by-two phase
    logic [6:0] limp_cnt_q; // Limp clock divider
    logic mult_tick; // Tick from the multiplier
    logic tick_d; // Next system clock tick
    logic [15:0] idx; // Word index of the access
    logic mapped; // Index hits a register
    logic setup; // APB setup cycle
    logic wr_ok; // Write accepted this cycle
    word_t rd_word; // Read mux output
    word_t status_word; // Status register view

    assign idx = paddr[17:2];
    assign setup = psel && !penable;
    // Writes take effect at the access edge only while unlocked
    assign wr_ok = psel && penable && pwrite && protected_access_unlock;
    assign pready = 1'b1;

    // ****************************************
    // Input pin synchronisers
    // ****************************************
    // Third stage only forms the edge; the first stage feeds nothing else
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            in_s1_q <= 1'b0;
            in_s2_q <= 1'b0;
            in_s3_q <= 1'b0;
        end else if (ce) begin
            in_s1_q <= input_clock;
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
        end
    end
    assign in_edge = in_s2_q && !in_s3_q;

    // Strap synchroniser keeps running through reset; held in reset it could never see the strap
    always_ff @(posedge mclk) begin
        if (ce) begin
            dis_s1_q <= pll_disable_pin_n;
            dis_s2_q <= dis_s1_q;
        end
    end

    // ****************************************
    // Input clock loss detector
    // ****************************************
    // Loss is a timeout on edges; the bound sets the slowest legal input
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            loss_cnt_q <= 9'h000;
            input_lost <= 1'b0;
        end else if (ce) begin
            if (in_edge) begin
                loss_cnt_q <= 9'h000;
                input_lost <= 1'b0;
            end else if (loss_cnt_q == 9'(`LOSS_CYCLES - 1)) begin
                input_lost <= 1'b1;
            end else begin
                loss_cnt_q <= loss_cnt_q + 9'h001;
            end
        end
    end

    // ****************************************
    // Strap capture
    // ****************************************
    // Sampled while reset is held, so the strap only counts during reset
    always_ff @(posedge mclk) begin
        if (ce && !reset_n) begin
            strap_off_q <= !dis_s2_q;
        end
    end

    // ****************************************
    // Ratio register
    // ****************************************
    // Only the pin reset clears it; a debugger reset keeps the clock rate
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ratio_q <= `RATIO_RESET;
        end else if (ce && wr_ok && idx == `IDX_RATIO) begin
            ratio_q <= pwdata[`RATIO_MSB:`RATIO_LSB];
        end
    end

    // ****************************************
    // Storage-only registers and watchdog control
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!reset_n || !debug_reset_n) begin
            fast_pre_q <= `REG_RESET;
            slow_pre_q <= `REG_RESET;
            gating_q <= `REG_RESET;
            lpa_q <= `REG_RESET;
            lpb_q <= `REG_RESET;
            wd_ctrl_q <= `REG_RESET;
        end else if (ce && wr_ok) begin
            case (idx)
                `IDX_FAST_PRESCALE: fast_pre_q <= pwdata[15:0];
                `IDX_SLOW_PRESCALE: slow_pre_q <= pwdata[15:0];
                `IDX_CLK_GATING: gating_q <= pwdata[15:0];
                `IDX_LOW_POWER_A: lpa_q <= pwdata[15:0];
                `IDX_LOW_POWER_B: lpb_q <= pwdata[15:0];
                `IDX_WD_CONTROL: wd_ctrl_q <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Clock source state machine
    // ****************************************
    // A new ratio above 1 relocks unless the strap holds PLL off; limp needs a non-zero code first
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q <= ST_BYPASS;
            lock_cnt_q <= 18'h00000;
        end else if (ce) begin
            case (state_q)
                ST_PLLOFF: begin
                    state_q <= ST_PLLOFF;
                end
                ST_BYPASS: begin
                    if (strap_off_q) begin
                        state_q <= ST_PLLOFF;
                    end else if (input_lost && ratio_q != 4'h0) begin
                        state_q <= ST_LIMP;
                    end else if (ratio_q > `RATIO_BYPASS_MAX) begin
                        state_q <= ST_LOCKING;
                        lock_cnt_q <= 18'h00000;
                    end
                end
                ST_LOCKING, ST_RUN: begin
                    if (input_lost && ratio_q != 4'h0) begin
                        state_q <= ST_LIMP;
                    end else if (wr_ok && idx == `IDX_RATIO) begin
                        state_q <= ST_BYPASS;
                    end else if (state_q == ST_LOCKING && in_edge) begin
                        if (lock_cnt_q == 18'(LOCK_CYCLES - 1)) begin
                            state_q <= ST_RUN;
                        end
                        lock_cnt_q <= lock_cnt_q + 18'h00001;
                    end
                end
                ST_LIMP: begin
                    if (!input_lost) begin
                        state_q <= ST_BYPASS;
                    end
                end
                default: begin
                    state_q <= ST_BYPASS;
                end
            endcase
        end
    end

    // ****************************************
    // System clock tick generation
    // ****************************************
    rate_multiplier rate_multiplier_inst (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .in_edge(in_edge),
        .mult(ratio_q),
        .tick(mult_tick)
    );

    // Divider and limp oscillator run always, so switching needs no restart
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            half_q <= 1'b0;
            limp_cnt_q <= 7'h00;
        end else if (ce) begin
            if (in_edge) begin
                half_q <= !half_q;
            end
            limp_cnt_q <= (limp_cnt_q == 7'(`LIMP_CYCLES - 1)) ? 7'h00 : limp_cnt_q + 7'h01;
        end
    end

    // Source select; while locking the output stays at input/2
    always_comb begin
        case (state_q)
            ST_PLLOFF: tick_d = in_edge;
            ST_BYPASS, ST_LOCKING: tick_d = in_edge && half_q;
            ST_RUN: tick_d = mult_tick;
            ST_LIMP: tick_d = (limp_cnt_q == 7'h00);
            default: tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            system_clock_tick <= 1'b0;
            limp_active <= 1'b0;
        end else if (ce) begin
            system_clock_tick <= tick_d;
            limp_active <= (state_q == ST_LIMP);
        end
    end

    // ****************************************
    // Watchdog counter and key
    // ****************************************
    // Counts input edges only, so it stalls on loss and software can see it
    always_ff @(posedge mclk) begin
        if (!reset_n || !debug_reset_n) begin
            wd_cnt_q <= 8'h00;
            wd_key_q <= `REG_RESET;
            key_armed_q <= 1'b0;
            watchdog_wake_irq <= 1'b0;
        end else if (ce) begin
            watchdog_wake_irq <= 1'b0;
            if (wr_ok && idx == `IDX_WD_KEY) begin
                wd_key_q <= pwdata[15:0];
                key_armed_q <= (pwdata[15:0] == `WD_KEY_FIRST);
            end
            if (wr_ok && idx == `IDX_WD_KEY && key_armed_q && pwdata[15:0] == `WD_KEY_SECOND) begin
                wd_cnt_q <= 8'h00;
            end else if (in_edge && !input_lost && !wd_ctrl_q[`WD_DISABLE_BIT]) begin
                wd_cnt_q <= wd_cnt_q + 8'h01;
                watchdog_wake_irq <= (wd_cnt_q == `WD_COUNT_MAX);
            end
        end
    end

    // ****************************************
    // APB read path
    // ****************************************
    always_comb begin
        status_word = 16'h0000;
        status_word[`STAT_LOCKED_BIT] = (state_q == ST_RUN);
        status_word[`STAT_LOST_BIT] = input_lost;
        status_word[`STAT_PLLOFF_BIT] = strap_off_q;
        status_word[`STAT_LIMP_BIT] = limp_active;
    end

    always_comb begin
        mapped = 1'b1;
        case (idx)
            `IDX_FAST_PRESCALE: rd_word = fast_pre_q;
            `IDX_SLOW_PRESCALE: rd_word = slow_pre_q;
            `IDX_CLK_GATING: rd_word = gating_q;
            `IDX_LOW_POWER_A: rd_word = lpa_q;
            `IDX_LOW_POWER_B: rd_word = lpb_q;
            `IDX_RATIO: rd_word = {12'h000, ratio_q};
            `IDX_STATUS: rd_word = status_word;
            `IDX_WD_COUNT: rd_word = {8'h00, wd_cnt_q};
            `IDX_WD_KEY: rd_word = wd_key_q;
            `IDX_WD_CONTROL: rd_word = wd_ctrl_q;
            default: begin
                rd_word = 16'h0000;
                mapped = 1'b0;
            end
        endcase
    end

    // Captured in setup; a locked read returns zero rather than an error
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce && setup) begin
            prdata <= (protected_access_unlock && !pwrite) ? {16'h0000, rd_word} : 32'h00000000;
            pslverr <= !mapped;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    locked_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && psel && penable && pwrite && !protected_access_unlock && debug_reset_n)
        |=> ($stable(ratio_q) && $stable(wd_ctrl_q)))
        else $error("locked write changed a register");
    ratio_upper_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && setup && idx == `IDX_RATIO && !pwrite) |=> (prdata[31:4] == 28'h0000000))
        else $error("ratio upper bits not zero");
    unmapped_err_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && setup && idx == 16'h701D) |=> pslverr)
        else $error("unmapped index gave no error");
    wd_freeze_a: assert property (@(posedge mclk) disable iff (!reset_n || !debug_reset_n)
        (input_lost && !(wr_ok && idx == `IDX_WD_KEY)) |=> $stable(wd_cnt_q))
        else $error("watchdog advanced while input lost");
    wd_advance_a: assert property (@(posedge mclk) disable iff (!reset_n || !debug_reset_n)
        (ce && in_edge && !input_lost && !wd_ctrl_q[`WD_DISABLE_BIT] && !wr_ok)
        |=> (wd_cnt_q == $past(wd_cnt_q) + 8'h01))
        else $error("watchdog did not advance");
    debug_keeps_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (!debug_reset_n && !wr_ok) |=> $stable(ratio_q))
        else $error("debug reset changed ratio");
    limp_entry_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && input_lost && ratio_q != 4'h0 && (state_q == ST_RUN || state_q == ST_LOCKING))
        |=> (state_q == ST_LIMP) ##1 limp_active)
        else $error("limp clock not entered");
    limp_needs_ratio_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q != ST_LIMP && ratio_q == 4'h0) |=> (state_q != ST_LIMP))
        else $error("limp entered with zero ratio");
    lock_time_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q == ST_LOCKING && $past(state_q) != ST_LOCKING)
        |=> (state_q != ST_RUN) [*3])
        else $error("PLL reported locked too early");
    plloff_tick_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && state_q == ST_PLLOFF) |=> (system_clock_tick == $past(in_edge)))
        else $error("disabled PLL did not pass input through");
    bypass_half_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && state_q == ST_BYPASS && in_edge && !half_q) |=> !system_clock_tick)
        else $error("bypass did not divide by two");
endmodule : clock_control

/* File: test/osc_model.sv */
// Crystal or external oscillator model driving the input clock pin
`timescale 1ns/1ns
module osc_model #(
    parameter int HALF_NS = 20 // Half period of the input clock
) (
    input wire logic run, // High while the oscillator swings
    output logic input_clock // Input clock pin
);
    // ****************************************
    // Oscillator
    // ****************************************
    // A dead oscillator rests low, so no stray edge reaches the block
    initial begin
        input_clock = 1'b0;
        forever begin
            #HALF_NS;
            input_clock = run ? ~input_clock : 1'b0;
        end
    end
endmodule : osc_model

/* File: test/test_pll_ratio_and_limp_clock_control.sv */
// Self-checking bench for the clock ratio and limp clock block
`timescale 1ns/1ns
`include "clock_ctrl_cfg.svh"
module test_pll_ratio_and_limp_clock_control;
    import clock_ctrl_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic mclk = 1'b0; // 250 MHz clock
    logic reset_n = 1'b0; // External reset pin
    logic debug_reset_n = 1'b1; // Debugger reset
    logic strap_n = 1'b1; // PLL disable strap
    logic unlock = 1'b0; // Protected access open
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB control
    logic [17:0] paddr = 18'h00000; // APB address
    logic [31:0] pwdata = 32'h00000000; // APB write data
    logic [31:0] prdata; // APB read data
    logic pready, pslverr, tick, wake, lost, limp; // Design outputs
    logic osc_run = 1'b1; // Oscillator running
    wire logic input_clock; // Oscillator output
    logic [31:0] rd, rd2; // Read results
    logic err; // Read error
    int fail_count = 0; // Mismatches
    int tests_run = 0; // Comparisons
    int cyc = 0; // Timeout counter
    always #2 mclk = ~mclk;
    clock_control #(.LOCK_CYCLES(8)) clock_control_inst (.mclk(mclk), .reset_n(reset_n),
        .debug_reset_n(debug_reset_n), .ce(1'b1), .input_clock(input_clock), .pll_disable_pin_n(strap_n),
        .protected_access_unlock(unlock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .system_clock_tick(tick),
        .watchdog_wake_irq(wake), .input_lost(lost), .limp_active(limp));
    osc_model osc_model_inst (.run(osc_run), .input_clock(input_clock));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Guards against a hung handshake
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Tick and count windows may straddle one edge either way
    task automatic chk_near(input int got, input int exp);
        tests_run++;
        if (got < exp - 1 || got > exp + 1) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_near
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic ticks(input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            @(posedge mclk);
            if (tick === 1'b1) n++;
        end
    endtask : ticks
    task automatic do_reset(input logic strap);
        @(posedge mclk);
        strap_n <= strap;
        reset_n <= 1'b0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
    endtask : do_reset
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_locked_access;
        apb(1'b0, `IDX_RATIO, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `IDX_RATIO, 32'h5);
        unlock <= 1'b1;
        apb(1'b0, `IDX_RATIO, 32'h0);
        chk(rd, 32'h0);
    endtask : t_locked_access
    task automatic t_register_map;
        logic [15:0] idx [5] = '{`IDX_FAST_PRESCALE, `IDX_SLOW_PRESCALE, `IDX_CLK_GATING,
            `IDX_LOW_POWER_A, `IDX_LOW_POWER_B};
        foreach (idx[i]) begin
            apb(1'b1, idx[i], 32'hFFFF_A5C0 + i);
            apb(1'b0, idx[i], 32'h0);
            chk(rd, 32'h0000_A5C0 + i);
        end
        apb(1'b1, `IDX_RATIO, 32'hFFF5);
        apb(1'b0, `IDX_RATIO, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, 16'h701D, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_register_map
    // Debugger reset clears storage but keeps the ratio
    task automatic t_debug_reset;
        @(posedge mclk);
        debug_reset_n <= 1'b0;
        @(posedge mclk);
        debug_reset_n <= 1'b1;
        unlock <= 1'b0;
        apb(1'b0, `IDX_RATIO, 32'h0);
        chk(rd, 32'h0);
        unlock <= 1'b1;
        apb(1'b0, `IDX_RATIO, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, `IDX_FAST_PRESCALE, 32'h0);
        chk(rd, 32'h0);
    endtask : t_debug_reset
    // Codes 0 to 10: lock wait, then ticks over 8 input periods
    task automatic t_ratio_codes;
        int n;
        for (int c = 0; c <= 10; c++) begin
            apb(1'b1, `IDX_RATIO, c);
            repeat (2) @(posedge mclk);
            apb(1'b0, `IDX_STATUS, 32'h0);
            chk(rd[0], 1'b0);
            repeat (130) @(posedge mclk);
            apb(1'b0, `IDX_STATUS, 32'h0);
            chk(rd[0], c >= 2);
            ticks(80, n);
            chk_near(n, c < 2 ? 4 : 4 * c);
        end
    endtask : t_ratio_codes
    // Counter advances per input edge, the key pair clears it, a wrap pulses the wake output
    task automatic t_watchdog_run;
        int n;
        apb(1'b0, `IDX_WD_COUNT, 32'h0);
        rd2 = rd;
        repeat (100) @(posedge mclk);
        apb(1'b0, `IDX_WD_COUNT, 32'h0);
        chk_near((int'(rd[7:0]) - int'(rd2[7:0]) + 256) % 256, 10);
        apb(1'b1, `IDX_WD_KEY, `WD_KEY_FIRST);
        apb(1'b1, `IDX_WD_KEY, `WD_KEY_SECOND);
        apb(1'b0, `IDX_WD_COUNT, 32'h0);
        chk_near(int'(rd[7:0]), 0);
        n = 0;
        repeat (2700) begin
            @(posedge mclk);
            if (wake === 1'b1) n++;
        end
        chk(n, 1);
    endtask : t_watchdog_run
    task automatic t_clock_loss(input logic [3:0] code);
        int n;
        apb(1'b1, `IDX_RATIO, code);
        repeat (150) @(posedge mclk);
        osc_run <= 1'b0;
        repeat (300) @(posedge mclk);
        chk({lost, limp}, {1'b1, code != 0});
        apb(1'b0, `IDX_WD_COUNT, 32'h0);
        rd2 = rd;
        ticks(250, n);
        if (code != 4'h0) begin
            chk_near(n, 2);
        end else begin
            chk(n, 0);
        end
        apb(1'b0, `IDX_WD_COUNT, 32'h0);
        chk(rd, rd2);
        osc_run <= 1'b1;
        repeat (300) @(posedge mclk);
        chk({lost, limp}, 2'b00);
    endtask : t_clock_loss
    task automatic t_strap_off;
        int n;
        do_reset(1'b0);
        apb(1'b0, `IDX_STATUS, 32'h0);
        chk(rd[2], 1'b1);
        apb(1'b0, `IDX_RATIO, 32'h0);
        chk(rd, 32'h0);
        ticks(80, n);
        chk_near(n, 8);
    endtask : t_strap_off
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        t_locked_access();
        t_register_map();
        t_debug_reset();
        t_ratio_codes();
        t_watchdog_run();
        t_clock_loss(4'h0);
        t_clock_loss(4'h4);
        t_strap_off();
        report_and_stop();
    end
endmodule : test_pll_ratio_and_limp_clock_control
